// [src/dq_cfg.svh]
// Offsets, field positions, reset values and timing counts of the acquisition register map
`ifndef DQ_CFG_SVH
`define DQ_CFG_SVH

// ----------------------------------------------------------------------------
// Window and offsets
// ----------------------------------------------------------------------------
`define DQ_WINDOW_BYTES 32
`define DQ_OFF_SAMPLE_LO 5'h00
`define DQ_OFF_SAMPLE_HI 5'h01
`define DQ_OFF_CTRL 5'h06
`define DQ_OFF_STATUS 5'h07
`define DQ_OFF_CLR_IRQ 5'h08
`define DQ_OFF_CLR_FIFO 5'h09
`define DQ_OFF_AO0_LO 5'h0A
`define DQ_OFF_AO0_HI 5'h0B
`define DQ_OFF_AO1_LO 5'h0C
`define DQ_OFF_AO1_HI 5'h0D
`define DQ_OFF_DIN_LO 5'h10
`define DQ_OFF_DIN_HI 5'h11
`define DQ_OFF_BOARD_IDENTIFIER 5'h14
`define DQ_OFF_FIRST_COUNTER_CLOCK_SELECT 5'h18
`define DQ_OFF_CNT1 5'h1A
`define DQ_OFF_CNT2 5'h1C

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define DQ_CTRL_SW 0
`define DQ_CTRL_PACER 1
`define DQ_CTRL_EXT 2
`define DQ_CTRL_GATE 3
`define DQ_CTRL_INTERRUPT_ENABLE_BIT 4
`define DQ_CTRL_ONEFH 5
`define DQ_CTRL_FIRST_COUNTER_CLOCK_SELECT 6
`define DQ_CTRL_RES 7
`define DQ_CTRL_RESET 8'h00
`define DQ_ST_EMPTY 0
`define DQ_ST_HALF 1
`define DQ_ST_FULL 2
`define DQ_ST_IRQ 3
`define DQ_ST_CAL 7

// ----------------------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------------------
`define DQ_FIFO_DEPTH 1024
`define DQ_FIFO_AW 10
`define DQ_FIFO_HALF 11'h0200
`define DQ_FIFO_FULL 11'h0400

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DQ_CLK_PERIOD_NS 10
`define DQ_TICK_PERIOD_NS 1000
`define DQ_TICK_CYCLES ((`DQ_TICK_PERIOD_NS) / (`DQ_CLK_PERIOD_NS))
`define DQ_MIN_CONV_GAP_NS 4000
`define DQ_MIN_CONV_GAP_CYCLES \
  (((`DQ_MIN_CONV_GAP_NS) + (`DQ_CLK_PERIOD_NS) - 1) / (`DQ_CLK_PERIOD_NS))

`endif

// [src/dq_pkg.sv]
// Types shared by the acquisition register map
package dq_pkg;

  // --------------------------------------------------------------------------
  // Host byte access
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dq_host_req_t;

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_WAIT = 3'b010,
    CONV_STORE = 3'b100
  } dq_conv_state_t;

endpackage : dq_pkg

// [src/dq_regmap.sv]
// Acquisition card register map, sample buffer, pacer counters and trigger logic
`timescale 1ns/10ps
`include "dq_cfg.svh"

// Summary of operation
// - Decode a 32-byte window of byte registers
// - Register address is base plus byte offset
// - 12-bit mode: sample bytes carry channel tag
// - 16-bit mode: full sample, low byte first
// - Offset 7 bits 3..0: irq, full, half, empty
// - Offset 6 reads back acquisition control bits
// - Resolution bit 6.7, calibration flag 7.7
// - Offsets 10..13 read back analog outputs
// - Offsets 16, 17 read digital input levels
// - Offset 20 returns 4-bit board identifier
// - Offsets 24, 26, 28 read counter bytes
// - Three 16-bit counters, two form pacer
// - Counter clocks: chained, 1MHz, selectable
// - Samples buffered in 1K-deep FIFO
// - Conversions never exceed 250 KS/s
// - Start from software, pacer or external
// - With control bit 0 set, a write to offset 0 starts conversion
// - Control bits 2..0 select trigger source
module dq_regmap (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire dq_pkg::dq_host_req_t host_req_i,
  output logic [7:0] rd_data_o,
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [3:0] conv_chan_i,
  input wire logic ext_trig_i,
  input wire logic pacer_gate_i,
  input wire logic first_counter_clock_select_ext_clk_i,
  input wire logic cal_busy_i,
  input wire logic [15:0] input_line_bits_i,
  input wire logic [3:0] board_identifier_bits_i,
  output logic [15:0] ao0_data_o,
  output logic [15:0] ao1_data_o,
  output logic irq_o,
  output logic pacer_out_o,
  output logic first_counter_clock_select_out_o
);

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic [15:0] dec16(input logic [15:0] v);
    dec16 = v - 16'h0001;
  endfunction : dec16

  logic rd_s;
  logic wr_s;
  logic [4:0] addr_s;
  logic [7:0] wdata_s;
  assign rd_s = host_req_i.rd;
  assign wr_s = host_req_i.wr;
  assign addr_s = host_req_i.addr;
  assign wdata_s = host_req_i.wdata;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [4:0] pin_last_reg;
  logic [15:0] din_meta_reg;
  logic [15:0] din_reg;
  logic [3:0] bid_meta_reg;
  logic [3:0] bid_reg;
  logic done_rise;
  logic ext_rise;
  logic ext_clk_rise;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
      pin_last_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {cal_busy_i, pacer_gate_i, first_counter_clock_select_ext_clk_i, ext_trig_i, conv_done_i};
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      din_meta_reg <= 16'h0000;
      din_reg <= 16'h0000;
      bid_meta_reg <= 4'h0;
      bid_reg <= 4'h0;
    end else begin
      din_meta_reg <= input_line_bits_i;
      din_reg <= din_meta_reg;
      bid_meta_reg <= board_identifier_bits_i;
      bid_reg <= bid_meta_reg;
    end
  end

  assign done_rise = pin_sync_reg[0] & ~pin_last_reg[0];
  assign ext_rise = pin_sync_reg[1] & ~pin_last_reg[1];
  assign ext_clk_rise = pin_sync_reg[2] & ~pin_last_reg[2];

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `DQ_CTRL_RESET;
    end else if (wr_s && hit(addr_s, `DQ_OFF_CTRL)) begin
      ctrl_reg <= wdata_s;
    end
  end

  // --------------------------------------------------------------------------
  // Analog output data
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ao0_data_o <= 16'h0000;
      ao1_data_o <= 16'h0000;
    end else if (wr_s) begin
      if (hit(addr_s, `DQ_OFF_AO0_LO)) ao0_data_o[7:0] <= wdata_s;
      if (hit(addr_s, `DQ_OFF_AO0_HI)) ao0_data_o[15:8] <= wdata_s;
      if (hit(addr_s, `DQ_OFF_AO1_LO)) ao1_data_o[7:0] <= wdata_s;
      if (hit(addr_s, `DQ_OFF_AO1_HI)) ao1_data_o[15:8] <= wdata_s;
    end
  end

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  logic [6:0] tick_cnt_reg;
  logic mhz_tick;
  logic [15:0] cnt_reg [3];
  logic [15:0] preset_reg [3];
  logic [7:0] latch_hi_reg [3];
  logic [2:0] wr_hi_reg;
  logic [2:0] rd_hi_reg;
  logic [2:0] cnt_tick;
  logic [2:0] cnt_term;
  logic [4:0] cnt_off [3];

  assign cnt_off[0] = `DQ_OFF_FIRST_COUNTER_CLOCK_SELECT;
  assign cnt_off[1] = `DQ_OFF_CNT1;
  assign cnt_off[2] = `DQ_OFF_CNT2;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 7'h00;
    end else if (tick_cnt_reg == 7'(`DQ_TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 7'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end
  end

  assign mhz_tick = (tick_cnt_reg == 7'(`DQ_TICK_CYCLES - 1));
  // Counter 1 runs from the 1MHz tick, counter 2 from counter 1's terminal count
  assign cnt_tick[0] = ctrl_reg[`DQ_CTRL_FIRST_COUNTER_CLOCK_SELECT] ? ext_clk_rise : mhz_tick;
  assign cnt_tick[1] = mhz_tick;
  assign cnt_tick[2] = cnt_term[1];

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    assign cnt_term[i] = cnt_tick[i] && (cnt_reg[i] == 16'h0001);

    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        cnt_reg[i] <= 16'h0000;
        preset_reg[i] <= 16'h0000;
        wr_hi_reg[i] <= 1'b0;
      end else if (wr_s && hit(addr_s, cnt_off[i])) begin
        wr_hi_reg[i] <= ~wr_hi_reg[i];
        if (wr_hi_reg[i]) begin
          preset_reg[i][15:8] <= wdata_s;
          cnt_reg[i] <= {wdata_s, preset_reg[i][7:0]};
        end else begin
          preset_reg[i][7:0] <= wdata_s;
        end
      end else if (cnt_term[i]) begin
        cnt_reg[i] <= preset_reg[i];
      end else if (cnt_tick[i]) begin
        cnt_reg[i] <= dec16(cnt_reg[i]);
      end
    end

    // Low byte read latches the high byte so the pair is coherent
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        rd_hi_reg[i] <= 1'b0;
        latch_hi_reg[i] <= 8'h00;
      end else if (rd_s && hit(addr_s, cnt_off[i])) begin
        rd_hi_reg[i] <= ~rd_hi_reg[i];
        if (!rd_hi_reg[i]) latch_hi_reg[i] <= cnt_reg[i][15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pacer_out_o <= 1'b0;
      first_counter_clock_select_out_o <= 1'b0;
    end else begin
      pacer_out_o <= cnt_term[2];
      first_counter_clock_select_out_o <= cnt_term[0];
    end
  end

  // --------------------------------------------------------------------------
  // Trigger selection
  // --------------------------------------------------------------------------
  logic sw_trig;
  logic pacer_trig;
  logic ext_trig;
  logic trig;
  logic [8:0] gap_reg;

  assign sw_trig = ctrl_reg[`DQ_CTRL_SW] && wr_s && hit(addr_s, `DQ_OFF_SAMPLE_LO);
  assign pacer_trig = ctrl_reg[`DQ_CTRL_PACER] && cnt_term[2]
    && (!ctrl_reg[`DQ_CTRL_GATE] || pin_sync_reg[3]);
  assign ext_trig = ctrl_reg[`DQ_CTRL_EXT] && ext_rise;
  assign trig = sw_trig || pacer_trig || ext_trig;

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  dq_pkg::dq_conv_state_t conv_state_reg;
  logic [15:0] conv_word_reg;
  logic push;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gap_reg <= 9'h000;
    end else if (trig && conv_state_reg == dq_pkg::CONV_IDLE && gap_reg == 9'h000) begin
      gap_reg <= 9'(`DQ_MIN_CONV_GAP_CYCLES - 1);
    end else if (gap_reg != 9'h000) begin
      gap_reg <= gap_reg - 9'h001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      conv_state_reg <= dq_pkg::CONV_IDLE;
      conv_start_o <= 1'b0;
      conv_word_reg <= 16'h0000;
    end else begin
      conv_start_o <= 1'b0;
      case (conv_state_reg)
        dq_pkg::CONV_IDLE: begin
          if (trig && gap_reg == 9'h000) begin
            conv_start_o <= 1'b1;
            conv_state_reg <= dq_pkg::CONV_WAIT;
          end
        end
        dq_pkg::CONV_WAIT: begin
          if (done_rise) begin
            if (ctrl_reg[`DQ_CTRL_RES]) begin
              conv_word_reg <= conv_data_i;
            end else begin
              conv_word_reg <= {conv_chan_i, conv_data_i[11:0]};
            end
            conv_state_reg <= dq_pkg::CONV_STORE;
          end
        end
        dq_pkg::CONV_STORE: begin
          conv_state_reg <= dq_pkg::CONV_IDLE;
        end
        default: begin
          conv_state_reg <= dq_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  assign push = (conv_state_reg == dq_pkg::CONV_STORE);

  // --------------------------------------------------------------------------
  // Sample buffer
  // --------------------------------------------------------------------------
  logic [15:0] fifo_mem [`DQ_FIFO_DEPTH];
  logic [`DQ_FIFO_AW-1:0] wr_ptr_reg;
  logic [`DQ_FIFO_AW-1:0] rd_ptr_reg;
  logic [10:0] level_reg;
  logic fifo_full;
  logic fifo_half;
  logic fifo_empty;
  logic do_push;
  logic do_pop;
  logic fifo_clr;

  assign fifo_full = (level_reg == `DQ_FIFO_FULL);
  assign fifo_half = (level_reg >= `DQ_FIFO_HALF);
  assign fifo_empty = (level_reg == 11'h000);
  assign fifo_clr = wr_s && hit(addr_s, `DQ_OFF_CLR_FIFO);
  assign do_push = push && !fifo_full;
  assign do_pop = rd_s && hit(addr_s, `DQ_OFF_SAMPLE_HI) && !fifo_empty;

  always_ff @(posedge ref_clk_i) begin
    if (do_push) fifo_mem[wr_ptr_reg] <= conv_word_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || fifo_clr) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= 11'h000;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + 10'h001;
      if (do_pop) rd_ptr_reg <= rd_ptr_reg + 10'h001;
      if (do_push && !do_pop) level_reg <= level_reg + 11'h001;
      if (do_pop && !do_push) level_reg <= level_reg - 11'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt flag
  // --------------------------------------------------------------------------
  logic irq_event;
  logic half_last_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) half_last_reg <= 1'b0;
    else half_last_reg <= fifo_half;
  end

  assign irq_event = ctrl_reg[`DQ_CTRL_INTERRUPT_ENABLE_BIT] && (ctrl_reg[`DQ_CTRL_ONEFH]
    ? (fifo_half && !half_last_reg) : do_push);

  // Event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else if (irq_event) begin
      irq_o <= 1'b1;
    end else if (wr_s && hit(addr_s, `DQ_OFF_CLR_IRQ)) begin
      irq_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [15:0] head;

  assign head = fifo_mem[rd_ptr_reg];

  always_comb begin
    rd_mux = 8'h00;
    case (addr_s)
      `DQ_OFF_SAMPLE_LO: rd_mux = head[7:0];
      `DQ_OFF_SAMPLE_HI: rd_mux = head[15:8];
      `DQ_OFF_CTRL: rd_mux = ctrl_reg;
      `DQ_OFF_STATUS: rd_mux = {pin_sync_reg[4], 3'h0, irq_o, fifo_full, fifo_half,
        fifo_empty};
      `DQ_OFF_AO0_LO: rd_mux = ao0_data_o[7:0];
      `DQ_OFF_AO0_HI: rd_mux = ao0_data_o[15:8];
      `DQ_OFF_AO1_LO: rd_mux = ao1_data_o[7:0];
      `DQ_OFF_AO1_HI: rd_mux = ao1_data_o[15:8];
      `DQ_OFF_DIN_LO: rd_mux = din_reg[7:0];
      `DQ_OFF_DIN_HI: rd_mux = din_reg[15:8];
      `DQ_OFF_BOARD_IDENTIFIER: rd_mux = {4'h0, bid_reg};
      `DQ_OFF_FIRST_COUNTER_CLOCK_SELECT: rd_mux = rd_hi_reg[0] ? latch_hi_reg[0] : cnt_reg[0][7:0];
      `DQ_OFF_CNT1: rd_mux = rd_hi_reg[1] ? latch_hi_reg[1] : cnt_reg[1][7:0];
      `DQ_OFF_CNT2: rd_mux = rd_hi_reg[2] ? latch_hi_reg[2] : cnt_reg[2][7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_s) begin
      rd_data_o <= rd_mux;
    end
  end

endmodule : dq_regmap

// [verification/dq_regmap_props.sv]
// Concurrent checks on the ports of the acquisition register map
`timescale 1ns/10ps
module dq_regmap_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire dq_pkg::dq_host_req_t host_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic conv_start_o,
  input wire logic [15:0] input_line_bits_i,
  input wire logic [15:0] ao0_data_o,
  input wire logic [15:0] ao1_data_o
);
  logic [7:0] ctrl_reg;
  logic [9:0] gap_reg;
  logic [15:0] din_prev_reg;
  logic [2:0] din_age_reg;
  logic rd_unused;
  logic [4:0] a;
  assign a = host_req_i.addr;
  assign rd_unused = host_req_i.rd && (a inside {2, 3, 4, 5, 8, 9, 14, 15, 18, 19, 21, 22, 23,
    25, 27, 29, 30, 31});
  // ----------------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= 8'h00;
    end else if (host_req_i.wr && a == 5'h06) begin
      ctrl_reg <= host_req_i.wdata;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gap_reg <= 10'h3FF;
    end else if (conv_start_o) begin
      gap_reg <= 10'h001;
    end else if (gap_reg != 10'h3FF) begin
      gap_reg <= gap_reg + 10'h001;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    din_prev_reg <= input_line_bits_i;
    if (input_line_bits_i != din_prev_reg) begin
      din_age_reg <= 3'd0;
    end else if (din_age_reg != 3'd7) begin
      din_age_reg <= din_age_reg + 3'd1;
    end
  end
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_start_width: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  chk_start_gap: assert property (conv_start_o |-> gap_reg >= 10'd400)
    else $error("conversions closer than 4 us");
  chk_ctrl_readback: assert property (host_req_i.rd && a == 5'h06 |=> rd_data_o == ctrl_reg)
    else $error("control readback differs from last write");
  chk_status_spare: assert property (host_req_i.rd && a == 5'h07 |=> rd_data_o[6:4] == 3'b000)
    else $error("status spare bits not zero");
  chk_unused_zero: assert property (rd_unused |=> rd_data_o == 8'h00)
    else $error("unused offset read not zero");
  chk_read_hold: assert property (!host_req_i.rd |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  chk_ao0_load: assert property (host_req_i.wr && a == 5'h0A |=>
    ao0_data_o[7:0] == $past(host_req_i.wdata))
    else $error("analog output 0 low byte not loaded");
  chk_ao1_load: assert property (host_req_i.wr && a == 5'h0D |=>
    ao1_data_o[15:8] == $past(host_req_i.wdata))
    else $error("analog output 1 high byte not loaded");
  chk_din_low: assert property (host_req_i.rd && a == 5'h10 && din_age_reg == 3'd7 |=>
    rd_data_o == $past(input_line_bits_i[7:0]))
    else $error("digital input low byte wrong");
  chk_board_pad: assert property (host_req_i.rd && a == 5'h14 |=> rd_data_o[7:4] == 4'h0)
    else $error("board identifier upper bits not zero");
  cov_start: cover property (conv_start_o);
  cov_ctrl_read: cover property (host_req_i.rd && a == 5'h06);
  cov_din_read: cover property (host_req_i.rd && a == 5'h10 && din_age_reg == 3'd7);
endmodule : dq_regmap_chk

bind dq_regmap dq_regmap_chk dq_regmap_chk_i (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .host_req_i(host_req_i),
  .rd_data_o(rd_data_o),
  .conv_start_o(conv_start_o),
  .input_line_bits_i(input_line_bits_i),
  .ao0_data_o(ao0_data_o),
  .ao1_data_o(ao1_data_o)
);

// [verification/dq_conv_model.sv]
// Converter model: answers each start pulse with a sample and a done edge
`timescale 1ns/10ps
module dq_conv_model (
  input wire logic ref_clk_i,
  input wire logic start_i,
  input wire logic [7:0] delay_i,
  input wire logic [15:0] sample_i,
  input wire logic [3:0] chan_i,
  output logic conv_done_o,
  output logic [15:0] conv_data_o,
  output logic [3:0] conv_chan_o
);
  initial begin
    conv_done_o = 1'b0;
    conv_data_o = 16'h0000;
    conv_chan_o = 4'h0;
    forever begin
      @(posedge ref_clk_i iff start_i);
      repeat (delay_i) @(posedge ref_clk_i);
      #1;
      conv_data_o = sample_i;
      conv_chan_o = chan_i;
      conv_done_o = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      #1;
      conv_done_o = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      // Lines stop carrying the sample two cycles after done has dropped
      conv_data_o = ~sample_i;
      conv_chan_o = ~chan_i;
    end
  end
endmodule : dq_conv_model

// [verification/dq_regmap_bench.sv]
// Self-checking bench for the acquisition register map
`timescale 1ns/10ps
module dq_regmap_bench;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  dq_pkg::dq_host_req_t req = '0;
  logic [7:0] rd_data;
  logic conv_start, conv_done, ext_trig = 1'b0, cal = 1'b0, ext_clk = 1'b0, irq;
  logic [15:0] conv_data, din = 16'h0000, ao0, ao1, smp = 16'h0000;
  logic [3:0] conv_chan, bid = 4'h0, chn = 4'h0;
  logic [7:0] dly = 8'h02;
  int fail_count = 0, num_checks = 0, cyc = 0, starts = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  dq_regmap dq_regmap_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .host_req_i(req),
    .rd_data_o(rd_data), .conv_start_o(conv_start), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .conv_chan_i(conv_chan), .ext_trig_i(ext_trig),
    .pacer_gate_i(1'b0), .first_counter_clock_select_ext_clk_i(ext_clk), .cal_busy_i(cal), .input_line_bits_i(din),
    .board_identifier_bits_i(bid), .ao0_data_o(ao0), .ao1_data_o(ao1), .irq_o(irq),
    .pacer_out_o(), .first_counter_clock_select_out_o());
  dq_conv_model dq_conv_model_i (.ref_clk_i(ref_clk_i), .start_i(conv_start), .delay_i(dly),
    .sample_i(smp), .chan_i(chn), .conv_done_o(conv_done), .conv_data_o(conv_data),
    .conv_chan_o(conv_chan));

  // ----------------------------------------------------------------------------
  // Start counter and hang guard
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cyc++;
    if (conv_start) starts++;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req = {1'b0, 1'b1, a, d};
    @(negedge ref_clk_i);
    req = '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    req = {1'b1, 1'b0, a, 8'h00};
    @(negedge ref_clk_i);
    req = '0;
    d = rd_data;
  endtask : rd
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rdchk
  function automatic logic [15:0] exp_word(input logic wide, input logic [15:0] s,
    input logic [3:0] c);
    return wide ? s : {c, s[11:0]};
  endfunction : exp_word
  // One conversion through software or the external pin, then read it back
  task automatic convert(input logic [7:0] ctrl);
    int n;
    logic [7:0] lo, hi;
    smp = 16'($urandom);
    chn = 4'($urandom);
    wr(5'h06, ctrl);
    repeat (420) @(negedge ref_clk_i);
    n = starts;
    if (ctrl[2]) begin
      ext_trig = 1'b1;
      repeat (200) @(negedge ref_clk_i);
      ext_trig = 1'b0;
    end else begin
      wr(5'h00, 8'($urandom));
    end
    repeat (3) @(negedge ref_clk_i);
    chk(16'(starts - n), 16'h0001);
    n = 0;
    do begin
      rd(5'h07, lo);
      n++;
    end while (lo[0] !== 1'b0 && n < 100);
    chk({8'h00, lo}, {12'h000, ctrl[4], 3'b000});
    n = starts;
    wr(5'h00, 8'($urandom));
    repeat (3) @(negedge ref_clk_i);
    chk(16'(starts - n), 16'h0000);
    rd(5'h00, lo);
    rd(5'h01, hi);
    chk({hi, lo}, exp_word(ctrl[7], smp, chn));
    rdchk(5'h07, {4'h0, ctrl[4], 3'b001});
    chk({15'h0000, irq}, {15'h0000, ctrl[4]});
    wr(5'h08, 8'h00);
    rdchk(5'h07, 8'h01);
  endtask : convert

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] aob [4];
    logic [15:0] w;
    logic [7:0] modes [5];
    logic [4:0] unused [18];
    modes = '{8'h81, 8'h01, 8'h84, 8'h04, 8'h91};
    unused = '{2, 3, 4, 5, 8, 9, 14, 15, 18, 19, 21, 22, 23, 25, 27, 29, 30, 31};
    void'($urandom(69));
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    rdchk(5'h07, 8'h01);
    rdchk(5'h06, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFA : (i == 1) ? 8'h00 : (8'($urandom) & 8'hFA);
      wr(5'h06, v);
      rdchk(5'h06, v);
    end
    for (int i = 0; i < 4; i++) begin
      aob[i] = 8'($urandom);
      wr(5'(10 + i), aob[i]);
      rdchk(5'(10 + i), aob[i]);
    end
    chk(ao0, {aob[1], aob[0]});
    chk(ao1, {aob[3], aob[2]});
    din = 16'($urandom);
    bid = 4'($urandom);
    cal = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    rdchk(5'h10, din[7:0]);
    rdchk(5'h11, din[15:8]);
    rdchk(5'h14, {4'h0, bid});
    rdchk(5'h07, 8'h81);
    cal = 1'b0;
    rdchk(5'h1C, 8'h00);
    rdchk(5'h1C, 8'h00);
    foreach (unused[i]) rdchk(unused[i], 8'h00);
    // Counter 0 on the external clock: load, three edges, read low then high
    wr(5'h06, 8'h40);
    v = 8'($urandom);
    wr(5'h18, v);
    wr(5'h18, 8'h5A);
    for (int i = 0; i < 3; i++) begin
      ext_clk = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ext_clk = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
    w = {8'h5A, v} - 16'h0003;
    rdchk(5'h18, w[7:0]);
    rdchk(5'h18, w[15:8]);
    for (int i = 0; i < 5; i++) begin
      dly = (i == 0) ? 8'h02 : 8'($urandom_range(3, 60));
      convert(modes[i]);
    end
    report_and_stop();
  end
endmodule : dq_regmap_bench
